// ### hw/uat_defines.svh
// Constants of the upper alarm threshold register and its two-wire target.
// Assumes a 100 MHz clock and two-wire inputs already synchronous to it.
`ifndef UAT_DEFINES_SVH
`define UAT_DEFINES_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define UAT_UPPER_PTR      8'h02
`define UAT_UPPER_RESET    16'h0000
`define UAT_DEV_ADDR       7'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UAT_RSV_HI_MSB     15
`define UAT_RSV_HI_LSB     13
`define UAT_SIGN_POS       12
`define UAT_MAG_MSB        11
`define UAT_MAG_LSB        2
`define UAT_RSV_LO_MSB     1
`define UAT_RSV_LO_LSB     0
`define UAT_VAL_RESET      11'h000

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define UAT_BITS_PER_BYTE  4'h8

`endif

// ### hw/uat_pkg.sv
// Types shared by the upper alarm threshold design.
// Assumes the defines header is compiled alongside.
`default_nettype none
package uat_pkg;

   // ----------------------------------------------------------------
   // Register layout
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] reserved_hi;
      logic       sign;
      logic [9:0] mag;
      logic [1:0] reserved_lo;
   } uat_thr_s;

   // ----------------------------------------------------------------
   // Two-wire target states
   // ----------------------------------------------------------------
   typedef enum logic [8:0] {
      ST_IDLE  = 9'b000000001,
      ST_ADDR  = 9'b000000010,
      ST_ACKA  = 9'b000000100,
      ST_PTR   = 9'b000001000,
      ST_ACKP  = 9'b000010000,
      ST_WDATA = 9'b000100000,
      ST_ACKW  = 9'b001000000,
      ST_RDATA = 9'b010000000,
      ST_RACK  = 9'b100000000
   } uat_state_e;

endpackage
`default_nettype wire

// ### hw/uat_thr_store.sv
// Storage of the upper alarm threshold value field.
// Assumes a committed 16-bit word arrives with a one-cycle strobe.
`include "uat_defines.svh"
`default_nettype none
module uat_thr_store
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             wr_en,
   input  wire logic [15:0]      wr_data,
   output uat_pkg::uat_thr_s     rd_data
);
   import uat_pkg::*;

   // ----------------------------------------------------------------
   // Value field storage
   // ----------------------------------------------------------------
   // Only the 11 writable bits are flops; reserved bits cost nothing
   logic [10:0] val_reg;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         val_reg <= `UAT_VAL_RESET;
      else if (wr_en)
         val_reg <= wr_data[`UAT_SIGN_POS:`UAT_MAG_LSB];
   end

   always_comb
   begin
      rd_data.reserved_hi = 3'h0;
      rd_data.sign        = val_reg[10];
      rd_data.mag         = val_reg[9:0];
      rd_data.reserved_lo = 2'h0;
   end

endmodule
`default_nettype wire

// ### hw/uat_top.sv
// Upper alarm threshold register behind a two-wire serial target.
// Assumes scl and sda inputs are already synchronous to clock.
`include "uat_defines.svh"
`default_nettype none
module uat_top
#(
   parameter logic [6:0] DEV_ADDR = `UAT_DEV_ADDR
)
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  sda_out,
   output logic                  sda_oe_n,
   output uat_pkg::uat_thr_s     upper_alarm_threshold
);
   import uat_pkg::*;

   // ----------------------------------------------------------------
   // Line events
   // ----------------------------------------------------------------
   logic       scl_q;
   logic       sda_q;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end

   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_ev = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_ev  = scl_in & scl_q & ~sda_q & sda_in;

   // ----------------------------------------------------------------
   // Target sequencer
   // ----------------------------------------------------------------
   uat_state_e  state_reg;
   logic [3:0]  cnt_reg;
   logic [7:0]  rx_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  ptr_reg;
   logic [7:0]  stage_reg;
   logic        hi_done_reg;
   logic        rd_lo_reg;
   logic        mack_reg;
   logic        commit_reg;
   logic [15:0] commit_data_reg;
   logic [15:0] thr_word;
   uat_thr_s    thr_rd;
   logic        byte_done;
   logic        addr_match;

   assign byte_done  = scl_fall && (cnt_reg == `UAT_BITS_PER_BYTE);
   assign addr_match = (rx_reg[7:1] == DEV_ADDR);
   assign thr_word   = thr_rd;

   function automatic logic [7:0] read_byte(input logic [7:0] ptr, input logic lo, input logic [15:0] word);
      logic [7:0] b;
      b = 8'h00;
      if (ptr == `UAT_UPPER_PTR)
         b = lo ? word[7:0] : word[15:8];
      return b;
   endfunction

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg       <= ST_IDLE;
         cnt_reg         <= 4'h0;
         rx_reg          <= 8'h00;
         tx_reg          <= 8'h00;
         ptr_reg         <= 8'h00;
         stage_reg       <= 8'h00;
         hi_done_reg     <= 1'b0;
         rd_lo_reg       <= 1'b0;
         mack_reg        <= 1'b0;
         commit_reg      <= 1'b0;
         commit_data_reg <= 16'h0000;
         sda_oe_n        <= 1'b1;
      end
      else
      begin
         commit_reg <= 1'b0;
         if (start_ev)
         begin
            // A half-written word is dropped on a new frame
            state_reg   <= ST_ADDR;
            cnt_reg     <= 4'h0;
            hi_done_reg <= 1'b0;
            sda_oe_n    <= 1'b1;
         end
         else if (stop_ev)
         begin
            state_reg   <= ST_IDLE;
            hi_done_reg <= 1'b0;
            sda_oe_n    <= 1'b1;
         end
         else
         begin
            unique case (state_reg)
               ST_IDLE:
               begin
                  sda_oe_n <= 1'b1;
               end
               ST_ADDR, ST_PTR, ST_WDATA:
               begin
                  if (scl_rise)
                  begin
                     rx_reg  <= {rx_reg[6:0], sda_in};
                     cnt_reg <= cnt_reg + 4'h1;
                  end
                  else if (byte_done)
                  begin
                     cnt_reg <= 4'h0;
                     if (state_reg == ST_ADDR)
                     begin
                        if (addr_match)
                        begin
                           sda_oe_n  <= 1'b0;
                           rd_lo_reg <= 1'b0;
                           state_reg <= ST_ACKA;
                        end
                        else
                           state_reg <= ST_IDLE;
                     end
                     else if (state_reg == ST_PTR)
                     begin
                        ptr_reg     <= rx_reg;
                        hi_done_reg <= 1'b0;
                        sda_oe_n    <= 1'b0;
                        state_reg   <= ST_ACKP;
                     end
                     else
                     begin
                        sda_oe_n  <= 1'b0;
                        state_reg <= ST_ACKW;
                        if (!hi_done_reg)
                        begin
                           stage_reg   <= rx_reg;
                           hi_done_reg <= 1'b1;
                        end
                        else
                        begin
                           // Both bytes land together so the comparator never sees half a value
                           hi_done_reg     <= 1'b0;
                           commit_reg      <= (ptr_reg == `UAT_UPPER_PTR);
                           commit_data_reg <= {stage_reg, rx_reg};
                        end
                     end
                  end
               end
               ST_ACKA:
               begin
                  if (scl_fall)
                  begin
                     if (rx_reg[0])
                     begin
                        tx_reg    <= {read_byte(ptr_reg, 1'b0, thr_word)} << 1;
                        sda_oe_n  <= read_byte(ptr_reg, 1'b0, thr_word) >> 7 == 8'h01;
                        rd_lo_reg <= 1'b1;
                        cnt_reg   <= 4'h1;
                        state_reg <= ST_RDATA;
                     end
                     else
                     begin
                        sda_oe_n  <= 1'b1;
                        state_reg <= ST_PTR;
                     end
                  end
               end
               ST_ACKP, ST_ACKW:
               begin
                  if (scl_fall)
                  begin
                     sda_oe_n  <= 1'b1;
                     state_reg <= ST_WDATA;
                  end
               end
               ST_RDATA:
               begin
                  if (byte_done)
                  begin
                     sda_oe_n  <= 1'b1;
                     cnt_reg   <= 4'h0;
                     state_reg <= ST_RACK;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe_n <= tx_reg[7];
                     tx_reg   <= {tx_reg[6:0], 1'b0};
                     cnt_reg  <= cnt_reg + 4'h1;
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                     mack_reg <= ~sda_in;
                  else if (scl_fall)
                  begin
                     if (mack_reg)
                     begin
                        tx_reg    <= {read_byte(ptr_reg, rd_lo_reg, thr_word)} << 1;
                        sda_oe_n  <= read_byte(ptr_reg, rd_lo_reg, thr_word) >> 7 == 8'h01;
                        rd_lo_reg <= ~rd_lo_reg;
                        cnt_reg   <= 4'h1;
                        state_reg <= ST_RDATA;
                     end
                     else
                        state_reg <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin data and register copy
   // ----------------------------------------------------------------
   // Open drain: the pin is only ever pulled low
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   uat_thr_store u_store
   (
      .clock   (clock),
      .nrst    (nrst),
      .wr_en   (commit_reg),
      .wr_data (commit_data_reg),
      .rd_data (thr_rd)
   );

   // Comparator copy, one cycle behind the store
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         upper_alarm_threshold <= `UAT_UPPER_RESET;
      else
         upper_alarm_threshold <= thr_rd;
   end

endmodule
`default_nettype wire

// ### verification/uat_assertions.sv
// Checker for the ports of the upper alarm threshold top.
// Assumes scl stays low for several clocks around each ack slot.
`default_nettype none
module uat_assertions
(
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic              scl_in,
   input wire logic              sda_in,
   input wire logic              sda_out,
   input wire logic              sda_oe_n,
   input wire uat_pkg::uat_thr_s upper_alarm_threshold
);
   timeunit 1ns;
   timeprecision 1ps;
   import uat_pkg::*;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // A word may only land while the target holds its ack low
   sequence ack_slot_s;
      !scl_in ##0 !sda_oe_n;
   endsequence
   rsv_hi_zero_a: assert property (upper_alarm_threshold.reserved_hi == 3'h0)
      else $error("reserved high bits not zero");
   sign_quiet_a: assert property ($changed(upper_alarm_threshold.sign) |-> !scl_in && !$past(scl_in))
      else $error("sign bit moved outside scl low");
   mag_slot_a: assert property ($changed(upper_alarm_threshold.mag) |-> ack_slot_s)
      else $error("magnitude moved outside ack slot");
   rsv_lo_zero_a: assert property (upper_alarm_threshold.reserved_lo == 2'h0)
      else $error("reserved low bits not zero");
   reset_clear_a: assert property ($rose(nrst) |-> upper_alarm_threshold == 16'h0000)
      else $error("threshold not clear after reset");
   upper_byte_a: assert property ($changed(upper_alarm_threshold[12:8]) |-> ack_slot_s)
      else $error("upper byte moved outside ack slot");
   rsv_write_a: assert property ($changed(upper_alarm_threshold) |-> (upper_alarm_threshold & 16'hE003) == 16'h0000)
      else $error("reserved bits written");
   quarter_bit_a: assert property ($changed(upper_alarm_threshold.mag[0]) |-> ack_slot_s)
      else $error("quarter degree bit moved outside ack slot");
   // Open drain: a driven high would fight the pull-up of other targets
   drive_low_a: assert property (sda_out == 1'b0)
      else $error("data pin value not low");
endmodule
bind uat_top uat_assertions u_chk (.clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .upper_alarm_threshold(upper_alarm_threshold));
`default_nettype wire

// ### verification/uat_host_model.sv
// Two-wire host that reaches the threshold register for the bench.
// Assumes sda is the AND of both open-drain drivers with a pull-up.
`default_nettype none
module uat_host_model
(
   input  wire logic clock,
   input  wire logic sda,
   output var logic  scl,
   output var logic  sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // ----------------------------------------------------------------
   // Bus phases, a quarter scl period apart
   // ----------------------------------------------------------------
   task automatic hold();
      repeat (4) @(posedge clock);
   endtask
   task automatic start();
      hold();
      sda_drv <= 1'b1;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b0;
   endtask
   task automatic stop();
      hold();
      sda_drv <= 1'b0;
      hold();
      scl <= 1'b1;
      hold();
      sda_drv <= 1'b1;
      hold();
   endtask
   task automatic bit_io(input logic b, output logic r);
      hold();
      sda_drv <= b;
      hold();
      scl <= 1'b1;
      hold();
      r = sda;
      hold();
      scl <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic am, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], q[i]);
      end
      bit_io(am, ack);
   endtask
   // Both bytes go out before the stop, else the target drops the word
   task automatic write_word(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w, output logic [3:0] k);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q, k[3]);
      xfer(p, 1'b1, q, k[2]);
      xfer(w[15:8], 1'b1, q, k[1]);
      xfer(w[7:0], 1'b1, q, k[0]);
      stop();
   endtask
   // Breaks the pairing on purpose: a lone high byte, then the stop
   task automatic write_half(input logic [6:0] a, input logic [7:0] p, input logic [7:0] h, output logic [2:0] k);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q, k[2]);
      xfer(p, 1'b1, q, k[1]);
      xfer(h, 1'b1, q, k[0]);
      stop();
   endtask
   task automatic read_word(input logic [6:0] a, input logic [7:0] p, output logic [15:0] w, output logic [3:0] k);
      logic [7:0] q;
      start();
      xfer({a, 1'b0}, 1'b1, q, k[3]);
      xfer(p, 1'b1, q, k[2]);
      start();
      xfer({a, 1'b1}, 1'b1, q, k[1]);
      xfer(8'hFF, 1'b0, w[15:8], k[0]);
      xfer(8'hFF, 1'b1, w[7:0], k[0]);
      k[0] = 1'b0;
      stop();
   endtask
endmodule
`default_nettype wire

// ### verification/upper_alarm_threshold_register_tb.sv
// Self-checking bench for the threshold register behind its two-wire target.
// Assumes the host model and the checker bound to the top.
`default_nettype none
module upper_alarm_threshold_register_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uat_pkg::*;
   logic        clock;
   logic        nrst;
   logic        scl;
   logic        host_sda;
   wire logic   sda_bus;
   logic        sda_out;
   logic        sda_oe_n;
   uat_thr_s    thr;
   int          fails;
   int          tests_run;
   logic [15:0] rd;
   logic [3:0]  ak;
   assign sda_bus = host_sda & (sda_oe_n | sda_out);
   uat_top dut (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .upper_alarm_threshold(thr));
   uat_host_model host (.clock(clock), .sda(sda_bus), .scl(scl), .sda_drv(host_sda));
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   task automatic t_reset();
      check("port after reset", 16'h0000, thr);
      host.read_word(7'h18, 8'h02, rd, ak);
      check("read after reset", 16'h0000, rd);
   endtask
   task automatic t_fields();
      logic [15:0] vals [6] = '{16'hFFFF, 16'h0004, 16'h1FFC, 16'h1000, 16'h0800, 16'h1004};
      foreach (vals[i])
      begin
         host.write_word(7'h18, 8'h02, vals[i], ak);
         check("write acks", 16'h0000, {12'h000, ak});
         check("port value", vals[i] & 16'h1FFC, thr);
         host.read_word(7'h18, 8'h02, rd, ak);
         check("read value", vals[i] & 16'h1FFC, rd);
      end
   endtask
   // Other pointers must neither store nor echo the threshold
   task automatic t_other_ptr();
      host.write_word(7'h18, 8'h03, 16'h0FFC, ak);
      check("port after other pointer", 16'h1004, thr);
      host.read_word(7'h18, 8'h03, rd, ak);
      check("other pointer read", 16'h0000, rd);
   endtask
   task automatic t_bad_addr();
      host.write_word(7'h19, 8'h02, 16'h0FFC, ak);
      check("address refused", 16'h0001, {15'h0000, ak[3]});
      check("port after bad address", 16'h1004, thr);
   endtask
   // A lone high byte before the stop must leave the stored word alone
   task automatic t_half_word();
      logic [2:0] hk;
      host.write_half(7'h18, 8'h02, 8'h0F, hk);
      check("half word acks", 16'h0000, {13'h0000, hk});
      check("port after half word", 16'h1004, thr);
   endtask
   task automatic t_reset_mid();
      host.write_word(7'h18, 8'h02, 16'h0FFC, ak);
      check("port before second reset", 16'h0FFC, thr);
      nrst <= 1'b0;
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      check("port after second reset", 16'h0000, thr);
      host.read_word(7'h18, 8'h02, rd, ak);
      check("read after second reset", 16'h0000, rd);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial
   begin
      nrst = 1'b0;
      fails = 0;
      tests_run = 0;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) @(posedge clock);
      t_reset();
      t_fields();
      t_other_ptr();
      t_bad_addr();
      t_half_word();
      t_reset_mid();
      final_report();
   end
   // Roughly three times the expected run length
   initial
   begin
      repeat (40000) @(posedge clock);
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
